//--- hdl/ccd_params.svh
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH

// ==========================================================
// Clock and pixel timing
`define CCD_CLK_MHZ 32'h28
`define CCD_PIX_MAX_MHZ 32'hA
// Least pixel period, rounded up to whole clocks
`define CCD_PIX_CYC ((`CCD_CLK_MHZ + `CCD_PIX_MAX_MHZ - 32'h1) / `CCD_PIX_MAX_MHZ)
`define CCD_VSTEP_NS 32'h3E8
`define CCD_VSTEP_CYC ((`CCD_VSTEP_NS * `CCD_CLK_MHZ + 32'h3E7) / 32'h3E8)

// ==========================================================
// Geometry
`define CCD_VREG_COUNT 13'h101F
`define CCD_NUM_LINES 13'h1020
`define CCD_LINE_PIX 13'h1031
`define CCD_VID_W 16
`define CCD_FIFO_DEPTH 8

// ==========================================================
// Column boundaries, first pixel of each group
`define CCD_COL_TEST0 13'h000B
`define CCD_COL_INACT1 13'h000C
`define CCD_COL_DARK0 13'h000F
`define CCD_COL_DARK0_EDGE 13'h0022
`define CCD_COL_BUF0 13'h0023
`define CCD_COL_ACT 13'h0024
`define CCD_COL_BUF1 13'h1024
`define CCD_COL_DARK1 13'h1025
`define CCD_COL_TEST1 13'h102E
`define CCD_COL_INACT2 13'h102F

// ==========================================================
// Row boundaries, first line of each group
`define CCD_ROW_DARK0_EDGE 13'h0013
`define CCD_ROW_BUF0 13'h0014
`define CCD_ROW_ACT 13'h0015
`define CCD_ROW_BUF1 13'h1015
`define CCD_ROW_DARK1 13'h1016

`endif

//--- hdl/ccd_pkg.sv
package ccd_pkg;

    // ==========================================================
    // Sample categories
    typedef enum logic [2:0] {
        CAT_INACTIVE,
        CAT_TEST,
        CAT_DARK,
        CAT_DARK_EDGE,
        CAT_BUFFER,
        CAT_ACTIVE
    } ccd_cat_t;

    // ==========================================================
    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INTEG,
        ST_VXFER,
        ST_HSHIFT,
        ST_HDRAIN
    } ccd_state_t;

endpackage

//--- hdl/ccd_pix_if.sv
`timescale 1ns/10ps
interface ccd_pix_if #(
    parameter int W = 19
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );
    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

//--- hdl/ccd_fifo.sv
`timescale 1ns/10ps
module ccd_fifo #(
    parameter int W = 19,
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    ccd_pix_if.snk push,
    ccd_pix_if.src pop
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic out_vld_q;
    logic [W-1:0] out_data_q;

    wire full = (cnt_q == (AW+1)'(DEPTH));
    wire do_wr = push.valid && !full;
    // Output register refills whenever it is empty or being taken
    wire do_rd = (cnt_q != '0) && (!out_vld_q || pop.ready);

    assign push.ready = !full;
    assign pop.valid = out_vld_q;
    assign pop.data = out_data_q;

    // ==========================================================
    // Storage
    always_ff @(posedge clock_in) begin
        if (do_wr) begin
            mem_q[wr_q] <= push.data;
        end
    end

    // ==========================================================
    // Pointers and count
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // ==========================================================
    // Registered head
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            out_vld_q <= 1'b0;
            out_data_q <= '0;
        end else if (do_rd) begin
            out_vld_q <= 1'b1;
            out_data_q <= mem_q[rd_q];
        end else if (pop.ready) begin
            out_vld_q <= 1'b0;
        end
    end
endmodule // ccd_fifo

//--- hdl/ccd_hseq.sv
`timescale 1ns/10ps
`include "ccd_params.svh"
module ccd_hseq
    import ccd_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic go_in,
    output logic busy_out,
    output logic h1_out,
    output logic h2_out,
    output logic rg_out,
    output logic smp_out
);
    localparam logic [2:0] CNT_SMP = 3'h1;
    localparam logic [2:0] CNT_RG = 3'h2;

    logic run_q;
    logic [2:0] cnt_q;
    logic h1_q;
    logic h2_q;
    logic rg_q;
    logic smp_q;

    wire start = go_in && !run_q;
    // Run ends early so the next pixel's rise lands on the reset pulse end
    wire last = run_q && (cnt_q == 3'(`CCD_PIX_CYC - 32'h2));
    wire h1_d = start;

    assign busy_out = run_q;
    assign h1_out = h1_q;
    assign h2_out = h2_q;
    assign rg_out = rg_q;
    assign smp_out = smp_q;

    // ==========================================================
    // Pixel phase counter
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            run_q <= 1'b0;
            cnt_q <= '0;
        end else if (start) begin
            run_q <= 1'b1;
            cnt_q <= '0;
        end else if (run_q) begin
            run_q <= !last;
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // ==========================================================
    // Phase outputs; idle leaves H2 high for vertical transfers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            h1_q <= 1'b0;
            h2_q <= 1'b1;
            rg_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            h1_q <= h1_d;
            h2_q <= !h1_d;
            smp_q <= run_q && (cnt_q == CNT_SMP);
            rg_q <= run_q && (cnt_q == CNT_RG);
        end
    end
endmodule // ccd_hseq

//--- hdl/ccd_readout_ctrl.sv
`timescale 1ns/10ps
`include "ccd_params.svh"
module ccd_readout_ctrl
    import ccd_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic start_frame_in,
    input wire logic integrate_in,
    input wire logic [`CCD_VID_W-1:0] video_sample_in,
    input wire logic pix_ready_in,
    output logic vertical_phase_one_out,
    output logic vertical_phase_two_out,
    output logic horizontal_phase_one_out,
    output logic horizontal_phase_two_out,
    output logic reset_gate_out,
    output logic adc_sample_out,
    output logic pix_valid_out,
    output logic [`CCD_VID_W-1:0] pix_data_out,
    output logic [2:0] pix_cat_out,
    output logic [12:0] line_index_out,
    output logic frame_busy_out,
    output logic frame_done_out
);
    localparam int DW = `CCD_VID_W + 3;
    localparam logic [5:0] VSTEP_LAST = 6'(`CCD_VSTEP_CYC - 32'h1);
    localparam logic [1:0] VSTEP_UP = 2'h0;
    localparam logic [1:0] VSTEP_XFER = 2'h1;
    localparam logic [1:0] VSTEP_SETTLE = 2'h2;

    // ==========================================================
    // Category decoding
    function automatic ccd_cat_t col_cat(input logic [12:0] p);
        ccd_cat_t c;
        c = CAT_INACTIVE;
        if (p < `CCD_COL_TEST0) begin
            c = CAT_INACTIVE;
        end else if (p < `CCD_COL_INACT1) begin
            c = CAT_TEST;
        end else if (p < `CCD_COL_DARK0) begin
            c = CAT_INACTIVE;
        end else if (p < `CCD_COL_DARK0_EDGE) begin
            c = CAT_DARK;
        end else if (p < `CCD_COL_BUF0) begin
            c = CAT_DARK_EDGE;
        end else if (p < `CCD_COL_ACT) begin
            c = CAT_BUFFER;
        end else if (p < `CCD_COL_BUF1) begin
            c = CAT_ACTIVE;
        end else if (p < `CCD_COL_DARK1) begin
            c = CAT_BUFFER;
        end else if (p == `CCD_COL_DARK1) begin
            c = CAT_DARK_EDGE;
        end else if (p < `CCD_COL_TEST1) begin
            c = CAT_DARK;
        end else if (p < `CCD_COL_INACT2) begin
            c = CAT_TEST;
        end
        return c;
    endfunction

    function automatic ccd_cat_t row_cat(input logic [12:0] l);
        ccd_cat_t c;
        c = CAT_DARK;
        if (l < `CCD_ROW_DARK0_EDGE) begin
            c = CAT_DARK;
        end else if (l < `CCD_ROW_BUF0) begin
            c = CAT_DARK_EDGE;
        end else if (l < `CCD_ROW_ACT) begin
            c = CAT_BUFFER;
        end else if (l < `CCD_ROW_BUF1) begin
            c = CAT_ACTIVE;
        end else if (l < `CCD_ROW_DARK1) begin
            c = CAT_BUFFER;
        end else if (l == `CCD_ROW_DARK1) begin
            c = CAT_DARK_EDGE;
        end
        return c;
    endfunction

    // Dark, edge and buffer row tags override active and buffer columns; test, inactive and dark columns keep theirs
    function automatic ccd_cat_t pix_cat(input logic [12:0] p, input logic [12:0] l);
        ccd_cat_t cc;
        ccd_cat_t rc;
        ccd_cat_t c;
        cc = col_cat(p);
        rc = row_cat(l);
        c = cc;
        if (cc == CAT_TEST || cc == CAT_INACTIVE) begin
            c = cc;
        end else if (rc == CAT_DARK || rc == CAT_DARK_EDGE) begin
            c = (cc == CAT_ACTIVE || cc == CAT_BUFFER) ? rc : cc;
        end else if (rc == CAT_BUFFER && cc == CAT_ACTIVE) begin
            c = CAT_BUFFER;
        end
        return c;
    endfunction

    // ==========================================================
    // Pin synchronisers, three stages
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] pin_q;
    logic [1:0] pin_prev_q;

    wire [1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    wire start_rise = pin_q[0] && !pin_prev_q[0];
    wire integ_lvl = pin_q[1];

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            s1_q <= {integrate_in, start_frame_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
            pin_prev_q <= pin_q;
        end
    end

    // ==========================================================
    // Carriers and sub-blocks
    ccd_pix_if #(.W(DW)) push_if ();
    ccd_pix_if #(.W(DW)) pop_if ();

    ccd_fifo #(
        .W(DW),
        .DEPTH(`CCD_FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .push(push_if.snk),
        .pop(pop_if.src)
    );

    logic hs_go;
    logic hs_busy;
    logic hs_smp;

    ccd_hseq u_hseq (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .go_in(hs_go),
        .busy_out(hs_busy),
        .h1_out(horizontal_phase_one_out),
        .h2_out(horizontal_phase_two_out),
        .rg_out(reset_gate_out),
        .smp_out(hs_smp)
    );

    assign adc_sample_out = hs_smp;
    assign pop_if.ready = pix_ready_in;
    assign pix_valid_out = pop_if.valid;
    assign pix_data_out = pop_if.data[`CCD_VID_W-1:0];
    assign pix_cat_out = pop_if.data[DW-1:`CCD_VID_W];

    // ==========================================================
    // Sequencer state
    ccd_state_t st_q;
    ccd_state_t st_d;
    logic [12:0] pix_q;
    logic [12:0] line_q;
    logic [1:0] vstep_q;
    logic [5:0] vcnt_q;
    logic v1_q;
    logic v2_q;
    ccd_cat_t cat_q;
    logic pv_q;
    logic [DW-1:0] pdata_q;
    logic busy_q;
    logic done_q;

    // A held sample must leave before the next pixel starts, so a full
    // FIFO stalls the horizontal clocks rather than dropping data
    wire push_free = !pv_q || push_if.ready;
    wire pix_last = (pix_q == `CCD_LINE_PIX - 13'h1);
    wire line_last = (line_q == `CCD_NUM_LINES - 13'h1);
    wire vstep_end = (vcnt_q == VSTEP_LAST);
    wire vxfer_end = vstep_end && (vstep_q == VSTEP_SETTLE);
    wire hs_idle = !hs_busy && !hs_go;
    wire frame_end = (st_q == ST_HDRAIN) && hs_idle && line_last;

    assign hs_go = (st_q == ST_HSHIFT) && !hs_busy && push_free;
    assign push_if.valid = pv_q;
    assign push_if.data = pdata_q;

    // ==========================================================
    // Next-state decode
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start_rise) begin
                    st_d = ST_VXFER;
                end else if (integ_lvl) begin
                    st_d = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (start_rise) begin
                    st_d = ST_VXFER;
                end else if (!integ_lvl) begin
                    st_d = ST_IDLE;
                end
            end
            ST_VXFER: begin
                if (vxfer_end) begin
                    st_d = ST_HSHIFT;
                end
            end
            ST_HSHIFT: begin
                if (hs_go && pix_last) begin
                    st_d = ST_HDRAIN;
                end
            end
            ST_HDRAIN: begin
                if (hs_idle) begin
                    st_d = line_last ? ST_IDLE : ST_VXFER;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Vertical phase stepping; both low outside transfers
    wire v1_d = (st_q == ST_VXFER) && (vstep_q == VSTEP_UP) && !vstep_end;
    wire v2_d = (st_q == ST_VXFER) && (vstep_q == VSTEP_XFER) && !vstep_end;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            vstep_q <= VSTEP_UP;
            vcnt_q <= '0;
            v1_q <= 1'b0;
            v2_q <= 1'b0;
        end else begin
            v1_q <= v1_d || ((st_d == ST_VXFER) && (st_q != ST_VXFER));
            v2_q <= v2_d || ((st_q == ST_VXFER) && vstep_end && (vstep_q == VSTEP_UP));
            if (st_q != ST_VXFER) begin
                vstep_q <= VSTEP_UP;
                vcnt_q <= '0;
            end else if (vstep_end) begin
                vstep_q <= vstep_q + 2'h1;
                vcnt_q <= '0;
            end else begin
                vcnt_q <= vcnt_q + 6'h1;
            end
        end
    end

    assign vertical_phase_one_out = v1_q;
    assign vertical_phase_two_out = v2_q;

    // ==========================================================
    // Pixel and line counters
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pix_q <= '0;
            line_q <= '0;
            cat_q <= CAT_INACTIVE;
        end else begin
            if ((st_q == ST_IDLE || st_q == ST_INTEG) && start_rise) begin
                line_q <= '0;
            end else if ((st_q == ST_HDRAIN) && hs_idle && !line_last) begin
                line_q <= line_q + 13'h1;
            end
            if (st_q == ST_VXFER) begin
                pix_q <= '0;
            end else if (hs_go) begin
                pix_q <= pix_q + 13'h1;
                cat_q <= pix_cat(pix_q, line_q);
            end
        end
    end

    // ==========================================================
    // Sample capture; inverted so more charge gives a larger code
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pv_q <= 1'b0;
            pdata_q <= '0;
        end else if (hs_smp) begin
            pv_q <= 1'b1;
            pdata_q <= {cat_q, ~video_sample_in};
        end else if (push_if.ready) begin
            pv_q <= 1'b0;
        end
    end

    // ==========================================================
    // Status
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= (st_d == ST_VXFER) || (st_d == ST_HSHIFT) || (st_d == ST_HDRAIN);
            done_q <= frame_end;
        end
    end

    assign frame_busy_out = busy_q;
    assign frame_done_out = done_q;
    assign line_index_out = line_q;

    // Pixel period is 4 clocks at 40 MHz, the 10 MHz ceiling
endmodule // ccd_readout_ctrl

//--- bench/ccd_readout_monitor.sv
`timescale 1ns/10ps
`include "ccd_params.svh"
module ccd_readout_monitor (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic pix_ready_in,
    input wire logic vertical_phase_one_out,
    input wire logic vertical_phase_two_out,
    input wire logic horizontal_phase_one_out,
    input wire logic horizontal_phase_two_out,
    input wire logic reset_gate_out,
    input wire logic adc_sample_out,
    input wire logic pix_valid_out,
    input wire logic [`CCD_VID_W-1:0] pix_data_out,
    input wire logic [2:0] pix_cat_out,
    input wire logic [12:0] line_index_out,
    input wire logic frame_busy_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================================
    // High time of vertical phase one
    logic [6:0] v1_len_q;
    logic [6:0] v1_len_d;
    assign v1_len_d = vertical_phase_one_out ? v1_len_q + 7'h01 : 7'h00;
    always_ff @(posedge clock_in) begin
        v1_len_q <= sys_rst_in ? 7'h00 : v1_len_d;
    end
    // ==========================================================
    // Checks
    a_idle_v_low: assert property (!frame_busy_out |->
        !vertical_phase_one_out && !vertical_phase_two_out)
        else $error("vertical phase high outside readout");
    a_h_compl: assert property (horizontal_phase_two_out == !horizontal_phase_one_out)
        else $error("horizontal phases not complementary");
    a_v1_len: assert property ($fell(vertical_phase_one_out) |-> v1_len_q == 7'h28)
        else $error("vertical phase one width wrong");
    a_v1_fall_h2: assert property ($fell(vertical_phase_one_out) |->
        vertical_phase_two_out && horizontal_phase_two_out)
        else $error("line transfer without phase two high");
    a_no_hshift_vxfer: assert property (vertical_phase_one_out || vertical_phase_two_out
        |-> !horizontal_phase_one_out)
        else $error("horizontal shift during vertical transfer");
    a_rg_after_adc: assert property ($rose(reset_gate_out) |-> $past(adc_sample_out))
        else $error("reset gate before sampling");
    a_adc_after_h1: assert property ($rose(adc_sample_out) |->
        $past(horizontal_phase_one_out, 2) && !$past(horizontal_phase_one_out))
        else $error("sample not after phase one fall");
    a_pix_rate: assert property ($rose(horizontal_phase_one_out) |=>
        !horizontal_phase_one_out [*3])
        else $error("pixel period below four clocks");
    a_stream_hold: assert property (pix_valid_out && !pix_ready_in |=> pix_valid_out
        && $stable(pix_data_out) && $stable(pix_cat_out))
        else $error("pixel stream changed while stalled");
    a_line_step: assert property ($changed(line_index_out) |->
        line_index_out == 13'($past(line_index_out) + 13'h1) || line_index_out == 13'h0)
        else $error("line index skipped");
endmodule // ccd_readout_monitor

bind ccd_readout_ctrl ccd_readout_monitor mon (.clock_in, .sys_rst_in, .pix_ready_in,
    .vertical_phase_one_out, .vertical_phase_two_out, .horizontal_phase_one_out,
    .horizontal_phase_two_out, .reset_gate_out, .adc_sample_out, .pix_valid_out,
    .pix_data_out, .pix_cat_out, .line_index_out, .frame_busy_out);

//--- bench/ccd_sensor_model.sv
`timescale 1ns/10ps
module ccd_sensor_model #(
    parameter logic [15:0] RESET_LVL = 16'hFFFF
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic v1_in,
    input wire logic h1_in,
    input wire logic h2_in,
    input wire logic rg_in,
    output logic [15:0] video_out,
    output int fault_out
);
    logic v1_q;
    logic h1_q;
    logic [15:0] node_q;
    int pix_q;
    int line_q;
    // More charge gives a lower level below reset
    assign video_out = RESET_LVL - node_q;
    always @(posedge clock_in) begin
        v1_q <= v1_in;
        h1_q <= h1_in;
        if (sys_rst_in) begin
            pix_q <= 0;
            line_q <= 0;
            node_q <= 16'h0000;
            fault_out <= 0;
        end else begin
            // Line enters the register on phase one falling
            if (v1_q && !v1_in) begin
                if (!h2_in || (line_q > 0 && pix_q != 4145)) begin
                    fault_out <= fault_out + 1;
                end
                line_q <= line_q + 1;
                pix_q <= 0;
            end
            // Packet index stands in for charge
            if (h1_q && !h1_in) begin
                if (pix_q >= 4145) begin
                    fault_out <= fault_out + 1;
                end
                node_q <= 16'(pix_q);
                pix_q <= pix_q + 1;
            end
            if (rg_in) begin
                node_q <= 16'h0000;
            end
        end
    end
endmodule // ccd_sensor_model

//--- bench/full_frame_ccd_readout_timing_test.sv
`timescale 1ns/10ps
`include "ccd_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module full_frame_ccd_readout_timing_test;
    import ccd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic integ = 1'b0;
    logic ready = 1'b1;
    logic v1, v2, h1, h2, rg, adc, pvalid, busy, done;
    logic [15:0] video;
    logic [15:0] pdata;
    logic [2:0] pcat;
    logic [12:0] line_idx;
    int fault;
    int num_errors = 0;
    int tests_run = 0;

    ccd_readout_ctrl dut (.clock_in(clk), .sys_rst_in(rst), .start_frame_in(start),
        .integrate_in(integ), .video_sample_in(video), .pix_ready_in(ready),
        .vertical_phase_one_out(v1), .vertical_phase_two_out(v2),
        .horizontal_phase_one_out(h1), .horizontal_phase_two_out(h2),
        .reset_gate_out(rg), .adc_sample_out(adc), .pix_valid_out(pvalid),
        .pix_data_out(pdata), .pix_cat_out(pcat), .line_index_out(line_idx),
        .frame_busy_out(busy), .frame_done_out(done));
    ccd_sensor_model sensor (.clock_in(clk), .sys_rst_in(rst), .v1_in(v1), .h1_in(h1),
        .h2_in(h2), .rg_in(rg), .video_out(video), .fault_out(fault));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task automatic summarize;
        $display("counts: tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check_idle;
        `CHK({v1, v2, h1, h2, rg, adc, pvalid, busy, done}, 9'b000100000)
        `CHK(line_idx, 13'h0000)
    endtask

    // Row 0 and 1 are dark rows; dark columns beside the buffer keep the edge tag
    function automatic logic [2:0] exp_cat(input int c);
        if (c == 11 || c == 4142) return CAT_TEST;
        if (c < 15 || c > 4142) return CAT_INACTIVE;
        if (c == 34 || c == 4133) return CAT_DARK_EDGE;
        return CAT_DARK;
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_integ;
        int n;
        integ = 1'b1;
        repeat (50) begin
            @(negedge clk);
            `CHK({v1, v2, busy}, 3'b000)
        end
        start = 1'b1;
        for (int i = 0; i < 20 && v1 !== 1'b1; i++) @(negedge clk);
        `CHK({v1, busy}, 2'b11)
        n = 0;
        while (v1 === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, 40)
        `CHK({v2, h2}, 2'b11)
        n = 0;
        while (v2 === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, 40)
        start = 1'b0;
        $display("test integ done");
    endtask

    task automatic t_line(input logic [12:0] line, input int stall_at, input bit poke);
        int n;
        int c;
        int rises;
        logic [2:0] ec;
        n = 0;
        c = 0;
        while (n < 4145 && c < 40000) begin
            @(negedge clk);
            c++;
            if (poke) start = (n >= 1000 && n < 1010);
            // Long stall fills the FIFO and must freeze the pixel clocks
            if (n == stall_at) begin
                ready = 1'b0;
                rises = 0;
                repeat (200) @(negedge clk);
                repeat (100) begin
                    @(negedge clk);
                    rises += (h1 !== 1'b0) ? 1 : 0;
                end
                `CHK(rises, 0)
                `CHK(pvalid, 1'b1)
                ready = 1'b1;
                stall_at = -1;
            end
            if (pvalid === 1'b1 && ready) begin
                if (n == 0) `CHK(line_idx, line)
                `CHK(pdata, 16'(n))
                ec = exp_cat(n);
                `CHK(pcat, ec)
                n++;
            end
        end
        start = 1'b0;
        `CHK(n, 4145)
        `CHK(fault, 0)
        $display("test line %0d done", line);
    endtask

    task automatic t_midreset;
        repeat (2000) @(negedge clk);
        `CHK(busy, 1'b1)
        rst = 1'b1;
        repeat (6) @(negedge clk);
        check_idle();
        rst = 1'b0;
        repeat (20) @(negedge clk);
        `CHK({v1, v2, busy}, 3'b000)
        $display("test midreset done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(negedge clk);
        check_idle();
        rst = 1'b0;
        t_integ();
        t_line(13'h0000, 2000, 1'b0);
        t_line(13'h0001, -1, 1'b1);
        t_midreset();
        summarize();
    end

    initial begin
        #1500000;
        num_errors++;
        summarize();
    end
endmodule // full_frame_ccd_readout_timing_test
